// [bench/tb_top.sv]
// Self-checking bench for the timer input capture block.
// Assumes the checker binds itself and the pins come from tic_pin_src.
`timescale 1ns/10ps
module tb_top
  import tic_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  tic_wb_req_t req = '0;
  tic_wb_rsp_t rsp;
  logic [3:0] src;
  logic [3:0] pin;
  logic pin_o, oe, irq;
  logic [2:0] irq_src, m;
  logic [15:0] cnt_m, e, v;
  logic [15:0] cap_m[4];
  logic [7:0] h, l;
  int failures = 0;
  int total_checks = 0;
  // The shared pin carries the device level while the device drives it
  assign pin = {oe ? pin_o : src[3], src[2:0]};
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) cnt_m <= rst_i ? 16'h0000 : cnt_m + 16'h0001;
  tic_pin_src tic_pin_src_inst (.pin_o(src));
  tic_timer_input_capture tic_timer_input_capture_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_rsp_o(rsp), .cap_pin_i(pin), .shared_pin_o(pin_o), .shared_pin_oe_o(oe), .irq_o(irq),
    .irq_src_o(irq_src));
  task chk(input logic [15:0] s, input logic [15:0] x);
    total_checks++;
    if (s !== x) begin
      failures++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, x);
    end
  endtask
  // No cycle limit of its own: only the watchdog ends a hung wait
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
    do begin
      @(posedge clk_i);
    end while (rsp.ack !== 1'b1);
    r = rsp.dat[7:0];
    req <= '0;
    @(posedge clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, h);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x);
    wb(1'b0, a, 8'h00, h);
    chk(h, x);
  endtask
  function automatic logic [7:0] ca(input int k);
    return TIC_CAP_BASE_OFF + 8'(k) * TIC_CAP_STRIDE;
  endfunction
  task cap(input int k, input logic [15:0] x);
    wb(1'b0, ca(k), 8'h00, h);
    wb(1'b0, ca(k) + TIC_CAP_LOW_OFF, 8'h00, l);
    chk({h, l}, x);
  endtask
  // Capture lands two edges after the sampling edge, so count then is now plus three
  task hit(input logic [3:0] p);
    tic_pin_src_inst.drive(p);
    e = cnt_m + 16'h0003;
    repeat (6) @(posedge clk_i);
  endtask
  task results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    results();
  end
  initial begin
    void'($urandom(32'h5ccd));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(TIC_EDGE_CTRL_OFF, TIC_EDGE_CTRL_RST);
    rd(TIC_PACC_CTRL_OFF, TIC_PACC_CTRL_RST);
    chk(oe, 1'b0);
    rd(8'h3c, 8'h00);
    v = cnt_m + 16'd100;
    wr(ca(3), v[15:8]);
    wr(ca(3) + TIC_CAP_LOW_OFF, v[7:0]);
    wr(TIC_FLAG_OFF, 8'h1f);
    repeat (100) @(posedge clk_i);
    rd(TIC_FLAG_OFF, 8'h10);
    wr(TIC_MASK_OFF, 8'h0f);
    for (int c = 0; c < 4; c++) begin
      wr(TIC_EDGE_CTRL_OFF, 8'(c * 21));
      for (int p = 0; p < 2; p++) begin
        if (p == 0) m = 3'($urandom_range(7, 1));
        wr(TIC_FLAG_OFF, 8'h1f);
        hit(p ? 4'h0 : {1'b0, m});
        chk(irq, c[p]);
        rd(TIC_FLAG_OFF, c[p] ? {5'h00, m} : 8'h00);
        for (int k = 0; k < 3; k++) begin
          if (c[p] && m[k]) begin
            cap(k, e);
            cap_m[k] = e;
          end
        end
      end
    end
    wr(TIC_EDGE_CTRL_OFF, 8'hc1);
    wr(TIC_FLAG_OFF, 8'h1f);
    hit(4'h8);
    rd(TIC_FLAG_OFF, 8'h00);
    wr(TIC_PACC_CTRL_OFF, 8'h04);
    hit(4'h1);
    rd(TIC_FLAG_OFF, 8'h09);
    chk(irq_src, 3'h1);
    cap(3, e);
    cap_m[0] = e;
    wr(ca(3), 8'h5a);
    wr(ca(3) + TIC_CAP_LOW_OFF, 8'ha5);
    cap(3, e);
    wr(TIC_FLAG_OFF, 8'h01);
    @(posedge clk_i);
    chk(irq_src, 3'h4);
    wr(TIC_MASK_OFF, 8'h00);
    chk(irq, 1'b0);
    wr(TIC_MASK_OFF, 8'h0f);
    wr(TIC_EDGE_CTRL_OFF, 8'h40);
    wr(TIC_PACC_CTRL_OFF, 8'h0c);
    wr(TIC_FLAG_OFF, 8'h1f);
    wr(TIC_PORT_OFF, 8'h01);
    repeat (6) @(posedge clk_i);
    chk({oe, pin_o}, 2'h3);
    rd(TIC_FLAG_OFF, 8'h08);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    cap(0, cap_m[0]);
    rd(TIC_EDGE_CTRL_OFF, 8'h00);
    results();
  end
endmodule

// [bench/tic_pin_src.sv]
// Signal sources that stand on the timer capture pins.
// Assumes the bench calls drive just after a rising clock edge.
`timescale 1ns/10ps
module tic_pin_src (
  output logic [3:0] pin_o
);
  // A level holds until the next call, so each pulse spans whole cycles
  logic [3:0] lvl_q = 4'h0;
  assign pin_o = lvl_q;
  task drive(input logic [3:0] v);
    lvl_q <= v;
  endtask
endmodule

// [bench/tic_timer_input_capture_checker.sv]
// Port-level assertions for the capture block.
// Assumes one clock domain, reset synchronous and active high.
`timescale 1ns/10ps
module tic_timer_input_capture_checker
  import tic_pkg::*;
#(
  parameter int N_CH = 4,
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tic_wb_req_t wb_req_i,
  input wire tic_wb_rsp_t wb_rsp_o,
  input wire logic [N_CH-1:0] cap_pin_i,
  input wire logic shared_pin_o,
  input wire logic shared_pin_oe_o,
  input wire logic irq_o,
  input wire logic [2:0] irq_src_o
);
  logic [4:0] mask_q;
  logic take;
  logic wr;
  assign take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  assign wr = take && wb_req_i.we && wb_req_i.sel[0];
  // Shadow of the mask, so the request line can be tied to it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= 5'h00;
    end else if (wr && wb_req_i.adr == TIC_MASK_OFF) begin
      mask_q <= wb_req_i.dat[4:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_after_take: assert property (take |=> wb_rsp_o.ack)
    else $error("request not acked");
  chk_ack_one_cycle: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held too long");
  chk_ack_needs_req: assert property (!(wb_req_i.cyc && wb_req_i.stb) |=> !wb_rsp_o.ack)
    else $error("ack without request");
  chk_oe_follows_dir: assert property (wr && wb_req_i.adr == TIC_PACC_CTRL_OFF |->
    ##2 shared_pin_oe_o == $past(wb_req_i.dat[TIC_DIR_BIT], 2)) else $error("pin enable wrong");
  chk_pin_follows_port: assert property (wr && wb_req_i.adr == TIC_PORT_OFF |->
    ##2 shared_pin_o == $past(wb_req_i.dat[0], 2)) else $error("pin level wrong");
  chk_reset_clears: assert property (disable iff (1'b0) $fell(rst_i) |->
    !shared_pin_oe_o && !irq_o && irq_src_o == TIC_SRC_NONE) else $error("outputs not reset");
  chk_irq_needs_mask: assert property (irq_o |-> $past(mask_q) != 5'h00)
    else $error("irq while all masked");
  chk_irq_has_cause: assert property ($rose(irq_o) && $past(mask_q) == $past(mask_q, 2) &&
    !$past(mask_q[4]) && !$past(shared_pin_oe_o) |-> $past(cap_pin_i, 4) != $past(cap_pin_i, 5))
    else $error("irq without pin edge");
endmodule
bind tic_timer_input_capture tic_timer_input_capture_checker #(.N_CH(N_CH), .CNT_W(CNT_W))
  tic_timer_input_capture_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .cap_pin_i(cap_pin_i), .shared_pin_o(shared_pin_o),
  .shared_pin_oe_o(shared_pin_oe_o), .irq_o(irq_o), .irq_src_o(irq_src_o));

// [common/tic_pkg.sv]
// Constants and carrier types for the timer input capture block.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
package tic_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] TIC_EDGE_CTRL_OFF = 8'h00;
  localparam logic [7:0] TIC_PACC_CTRL_OFF = 8'h04;
  localparam logic [7:0] TIC_FLAG_OFF = 8'h08;
  localparam logic [7:0] TIC_MASK_OFF = 8'h0c;
  localparam logic [7:0] TIC_COUNT_OFF = 8'h10;
  localparam logic [7:0] TIC_CAP_BASE_OFF = 8'h14;
  localparam logic [7:0] TIC_CAP_STRIDE = 8'h08;
  localparam logic [7:0] TIC_CAP_LOW_OFF = 8'h04;
  localparam logic [7:0] TIC_PORT_OFF = 8'h34;
  localparam logic [7:0] TIC_IRQ_SRC_OFF = 8'h38;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TIC_DIR_BIT = 3;
  localparam int TIC_SEL4_BIT = 2;
  localparam int TIC_OC5_FLAG_BIT = 4;
  localparam int TIC_CH4 = 3;
  localparam int TIC_FLAG_W = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] TIC_EDGE_CTRL_RST = 8'h00;
  localparam logic [7:0] TIC_PACC_CTRL_RST = 8'h00;
  localparam logic [15:0] TIC_COUNT_RST = 16'h0000;

  // Two-bit edge field encoding
  typedef enum logic [1:0] {
    TIC_EDGE_OFF = 2'b00,
    TIC_EDGE_RISE = 2'b01,
    TIC_EDGE_FALL = 2'b10,
    TIC_EDGE_ANY = 2'b11
  } tic_edge_t;

  // Pending source code, highest priority first; zero means none
  localparam logic [2:0] TIC_SRC_NONE = 3'h0;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tic_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } tic_wb_rsp_t;

endpackage

// [hdl/tic_timer_input_capture.sv]
// Timer input capture unit with a Wishbone slave register file.
// Assumes pins synchronous-free inputs sampled on clk_i, and one clock.
//
// What this block does
// - Edge field picks off, rise, fall, any
// - Four edge fields, all cleared on reset
// - Channel four needs capture-four select set
// - Select cleared on reset: fifth compare
// - Direction bit cleared on reset: pin input
// - Output pin writes can trigger channel four
// - Writes to shared register ignored in capture
// - Same-cycle edges latch identical count
// - Whole 16-bit count copied at once
// - Capture never sees a changing count
// - Reset leaves capture registers alone
// - Capture read as high and low bytes
// - Captures 1-3 outrank shared channel
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/10ps

module tic_timer_input_capture
  import tic_pkg::*;
#(
  parameter int N_CH = 4,
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tic_wb_req_t wb_req_i,
  output tic_wb_rsp_t wb_rsp_o,
  input wire logic [N_CH-1:0] cap_pin_i,
  output logic shared_pin_o,
  output logic shared_pin_oe_o,
  output logic irq_o,
  output logic [2:0] irq_src_o
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // The byte map and the flag layout are built for four 16-bit channels only
  if (N_CH != 4) begin : g_bad_ch
    $error("N_CH must be 4");
  end
  if (CNT_W != 16) begin : g_bad_cnt
    $error("CNT_W must be 16");
  end

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic edge_hit(input logic [1:0] fld, input logic now, input logic prev);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = ~now & prev;
    unique case (tic_edge_t'(fld))
      TIC_EDGE_OFF: edge_hit = 1'b0;
      TIC_EDGE_RISE: edge_hit = rise;
      TIC_EDGE_FALL: edge_hit = fall;
      TIC_EDGE_ANY: edge_hit = rise | fall;
    endcase
  endfunction

  function automatic logic [7:0] cap_off(input int ch, input logic low);
    cap_off = 8'(TIC_CAP_BASE_OFF + TIC_CAP_STRIDE * 8'(ch) + (low ? TIC_CAP_LOW_OFF : 8'h00));
  endfunction

  // True for a taken write whose address is the given byte offset
  function automatic logic wr_at(input logic en, input logic [7:0] adr, input logic [7:0] off);
    wr_at = en & (adr == off);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [CNT_W-1:0] count_q;
  logic [7:0] edge_ctrl_q;
  logic [7:0] pacc_ctrl_q;
  logic [TIC_FLAG_W-1:0] flag_q;
  logic [TIC_FLAG_W-1:0] mask_q;
  logic port_q;
  logic [N_CH-1:0] sync1_q;
  logic [N_CH-1:0] sync2_q;
  logic [N_CH-1:0] prev_q;
  logic [CNT_W-1:0] cap_q [N_CH];
  logic ack_q;
  logic [31:0] rdat_q;
  logic irq_q;
  logic [2:0] src_q;
  logic oe_q;
  logic pin_q;

  logic sel4;
  logic dir;
  logic req;
  logic wr;
  logic [N_CH-1:0] pin_src;
  logic [N_CH-1:0] hit;
  logic oc5_match;
  logic [TIC_FLAG_W-1:0] flag_set;
  logic [TIC_FLAG_W-1:0] flag_clr;
  logic [TIC_FLAG_W-1:0] pend;
  logic [2:0] src_d;
  logic [31:0] rdat_d;
  logic wr_edge;
  logic wr_pacc;
  logic wr_flag;
  logic wr_mask;
  logic wr_port;
  logic wr_cap4_hi;
  logic wr_cap4_lo;

  assign sel4 = pacc_ctrl_q[TIC_SEL4_BIT];
  assign dir = pacc_ctrl_q[TIC_DIR_BIT];
  // A request is served once; ack_q blocks a second action on the same request
  assign req = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  // Registers are byte wide in the low lane, so only lane 0 writes
  assign wr = req & wb_req_i.we & wb_req_i.sel[0];

  // ****************************************
  // Write strobes
  // ****************************************
  assign wr_edge = wr_at(wr, wb_req_i.adr, TIC_EDGE_CTRL_OFF);
  assign wr_pacc = wr_at(wr, wb_req_i.adr, TIC_PACC_CTRL_OFF);
  assign wr_flag = wr_at(wr, wb_req_i.adr, TIC_FLAG_OFF);
  assign wr_mask = wr_at(wr, wb_req_i.adr, TIC_MASK_OFF);
  assign wr_port = wr_at(wr, wb_req_i.adr, TIC_PORT_OFF);
  assign wr_cap4_hi = wr_at(wr, wb_req_i.adr, cap_off(TIC_CH4, 1'b0));
  assign wr_cap4_lo = wr_at(wr, wb_req_i.adr, cap_off(TIC_CH4, 1'b1));

  // ****************************************
  // Free-running counter
  // ****************************************
  // Captures take the value held before this increment at the same edge,
  // which stands in for latching on the opposite half-cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= TIC_COUNT_RST;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  // ****************************************
  // Pin synchroniser and edge detection
  // ****************************************
  // With the pin driven, channel four watches the value the port drives
  always_comb begin
    pin_src = cap_pin_i;
    if (dir) begin
      pin_src[TIC_CH4] = port_q;
    end
  end

  // No reset: the stages keep tracking the pins through reset, so a pin
  // that is already high never shows a false edge right after reset
  always_ff @(posedge clk_i) begin
    sync1_q <= pin_src;
    sync2_q <= sync1_q;
    prev_q <= sync2_q;
  end

  always_comb begin
    for (int k = 0; k < N_CH; k++) begin
      hit[k] = edge_hit(edge_ctrl_q[2*k +: 2], sync2_q[k], prev_q[k]);
    end
    hit[TIC_CH4] = hit[TIC_CH4] & sel4;
  end

  // ****************************************
  // Capture registers
  // ****************************************
  // No reset here: contents survive reset. All channels sample the
  // same pre-increment count at the same edge, so the value is the one
  // that was stable through the whole cycle.
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < N_CH; k++) begin
      if (hit[k]) begin
        cap_q[k] <= count_q;
      end else if (k == TIC_CH4 && !sel4) begin
        if (wr_cap4_hi) begin
          cap_q[k][15:8] <= wb_req_i.dat[7:0];
        end else if (wr_cap4_lo) begin
          cap_q[k][7:0] <= wb_req_i.dat[7:0];
        end
      end
    end
  end
  // With sel4 set the branch above is closed, so writes leave it untouched

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_ctrl_q <= TIC_EDGE_CTRL_RST;
    end else if (wr_edge) begin
      edge_ctrl_q <= wb_req_i.dat[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pacc_ctrl_q <= TIC_PACC_CTRL_RST;
    end else if (wr_pacc) begin
      pacc_ctrl_q <= wb_req_i.dat[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= wb_req_i.dat[TIC_FLAG_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_q <= 1'b0;
    end else if (wr_port) begin
      port_q <= wb_req_i.dat[0];
    end
  end

  // ****************************************
  // Flags and interrupt
  // ****************************************
  // Fifth compare runs only while the shared register is not capturing
  assign oc5_match = ~sel4 & (count_q == cap_q[TIC_CH4]);

  always_comb begin
    flag_set = {oc5_match, hit};
    flag_clr = '0;
    if (wr_flag) begin
      flag_clr = wb_req_i.dat[TIC_FLAG_W-1:0];
    end
  end

  // An event in the clearing cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  assign pend = flag_q & mask_q;

  // Source code: 1..3 for captures one to three, 4 for the shared channel
  always_comb begin
    src_d = TIC_SRC_NONE;
    if (pend[0]) begin
      src_d = 3'h1;
    end else if (pend[1]) begin
      src_d = 3'h2;
    end else if (pend[2]) begin
      src_d = 3'h3;
    end else if (pend[TIC_CH4] | pend[TIC_OC5_FLAG_BIT]) begin
      src_d = 3'h4;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
      src_q <= TIC_SRC_NONE;
    end else begin
      irq_q <= |pend;
      src_q <= src_d;
    end
  end

  // ****************************************
  // Shared pin drive
  // ****************************************
  // Both pin outputs are registered so the pin never glitches on a bus write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      oe_q <= dir;
      pin_q <= port_q;
    end
  end

  // ****************************************
  // Wishbone read path
  // ****************************************
  // Map: 0x00 edge fields, 0x04 pulse control, 0x08 flags, 0x0c mask,
  // 0x10 count, 0x14 + 8k capture high byte, 0x18 + 8k low byte,
  // 0x34 port data, 0x38 pending source; all but the 16-bit count sit in lane 0.
  // Capture bytes are not latched as a pair: a capture between the two
  // reads mixes old and new halves, so software must guard against it.
  always_comb begin
    rdat_d = 32'h0000_0000;
    unique case (wb_req_i.adr)
      TIC_EDGE_CTRL_OFF: rdat_d[7:0] = edge_ctrl_q;
      TIC_PACC_CTRL_OFF: rdat_d[7:0] = pacc_ctrl_q;
      TIC_FLAG_OFF: rdat_d[TIC_FLAG_W-1:0] = flag_q;
      TIC_MASK_OFF: rdat_d[TIC_FLAG_W-1:0] = mask_q;
      TIC_COUNT_OFF: rdat_d[15:0] = count_q;
      TIC_PORT_OFF: rdat_d[0] = port_q;
      TIC_IRQ_SRC_OFF: rdat_d[2:0] = src_q;
      default: begin
        for (int k = 0; k < N_CH; k++) begin
          if (wb_req_i.adr == cap_off(k, 1'b0)) begin
            rdat_d[7:0] = cap_q[k][15:8];
          end
          if (wb_req_i.adr == cap_off(k, 1'b1)) begin
            rdat_d[7:0] = cap_q[k][7:0];
          end
        end
      end
    endcase
  end

  // Every request is answered, unmapped ones with zero data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req && !wb_req_i.we) begin
        rdat_q <= rdat_d;
      end
    end
  end

  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;
  assign irq_o = irq_q;
  assign irq_src_o = src_q;
  assign shared_pin_o = pin_q;
  assign shared_pin_oe_o = oe_q;

endmodule
